// [logic/adc_ctrl_pkg.sv]
// Constants, register map and types for the converter control block.
//
// Notes on behaviour
// - Gain-stage select routes the input through a gain-of-8 amplifier.
// - Input above high reference reads result_high FFh and low bits 11b.
// - Input below low reference reads zero in both result fields.
// - Power-on enables the converter; conversions repeat until it clears.
// - Each completed conversion sets done flag and loads the 10-bit result.
// - Reading result_high clears the done flag; software cannot write it.
// - Channel field bits 2:0 selects analog input n, n from 0 to 6.
// - Converter clock: /2, undivided when fast and quarter clear, /4 when quarter set, even with fast.
// - Amplifier is powered with the converter by the power-on bit.
// - result_high holds bits 9:2; low register bits 1:0 hold bits 1:0.
// - Offset-calibration bit 4 ties the amplifier input to 0V.
// - Low register bits 7:5 always read zero.
// - Idle sleep leaves conversions alone; deep stop disables, then waits.
// - Clearing power-on switches off converter and amplifier.
package adc_ctrl_pkg;

	// ***************************************************
	// Register indices and byte addresses
	// ***************************************************
	localparam logic [7:0]  IDX_CSR  = 8'h34;
	localparam logic [7:0]  IDX_HIGH = 8'h35;
	localparam logic [7:0]  IDX_LOW  = 8'h36;
	localparam logic [11:0] ADDR_CSR  = {2'h0, IDX_CSR, 2'h0};
	localparam logic [11:0] ADDR_HIGH = {2'h0, IDX_HIGH, 2'h0};
	localparam logic [11:0] ADDR_LOW  = {2'h0, IDX_LOW, 2'h0};

	// ***************************************************
	// Field positions
	// ***************************************************
	localparam int CSR_DONE  = 7;
	localparam int CSR_FAST  = 6;
	localparam int CSR_POWER = 5;
	localparam int LOW_CAL   = 4;
	localparam int LOW_QUART = 3;
	localparam int LOW_GAIN  = 2;

	localparam logic [2:0] CHAN_RESET = 3'h0;
	localparam logic [9:0] CODE_MSB   = 10'h200;
	localparam logic [3:0] BIT_TOP    = 4'h9;

	// ***************************************************
	// Timing
	// ***************************************************
	localparam int CLK_KHZ      = 25000;
	localparam int T_STAB_NS    = 10000;
	localparam int STAB_CYCLES  = (T_STAB_NS * CLK_KHZ + 999999) / 1000000;
	localparam logic [11:0] STAB_COUNT = 12'(STAB_CYCLES);
	localparam logic [3:0]  SAMPLE_TICKS = 4'h8;
	localparam logic [3:0]  BIT_TICKS    = 4'h4;

	typedef enum logic [1:0] {
		ST_IDLE    = 2'b00,
		ST_SAMPLE  = 2'b01,
		ST_CONVERT = 2'b11,
		ST_DONE    = 2'b10
	} conv_state_t;

endpackage

// [logic/adc_control_interface.sv]
// Converter control, result registers and APB slave of the 10-bit converter.
`timescale 1ns/1ns

module adc_control_interface
	import adc_ctrl_pkg::*;
(
	// Clock and reset
	input  wire logic        MCLK,
	input  wire logic        RST_B,

	// APB slave
	input  wire logic        PSEL,
	input  wire logic        PENABLE,
	input  wire logic        PWRITE,
	input  wire logic [11:0] PADDR,
	input  wire logic [31:0] PWDATA,
	output logic      [31:0] PRDATA,
	output logic             PREADY,
	output logic             PSLVERR,

	// Low-power state from the core
	input  wire logic        HALT_MODE,

	// Analog conversion macro
	input  wire logic        COMP_ABOVE,
	output logic             CONV_POWER,
	output logic             AMP_POWER,
	output logic             GAIN_STAGE_SELECT,
	output logic             OFFSET_CALIBRATION,
	output logic      [2:0]  CHANNEL_SELECT,
	output logic             CONVERTER_CLOCK,
	output logic             SAMPLE_HOLD,
	output logic      [9:0]  TRIAL_CODE
);

	// ***************************************************
	// Functions
	// ***************************************************
	function automatic logic [9:0] bit_mask(input logic [3:0] idx);
		bit_mask = 10'(10'h001 << idx);
	endfunction

	function automatic logic tick_due(input logic fast, input logic quarter,
	                                  input logic [1:0] cnt);
		if (quarter) begin
			tick_due = (cnt == 2'h3);
		end else if (fast) begin
			tick_due = 1'b1;
		end else begin
			tick_due = cnt[0];
		end
	endfunction

	// ***************************************************
	// Declarations
	// ***************************************************
	logic        power_q;
	logic        fast_q;
	logic [2:0]  chan_q;
	logic        cal_q;
	logic        quarter_q;
	logic        gain_q;
	logic        done_q;
	logic [9:0]  result_q;
	logic [31:0] prdata_q;
	logic        pslverr_q;
	logic        high_stale_q;
	logic [1:0]  div_q;
	logic        tick;
	logic        comp_meta_q;
	logic        comp_q;
	logic        halt_q;
	logic [11:0] stab_q;
	logic        run;
	conv_state_t state_q;
	logic [3:0]  step_q;
	logic [3:0]  bit_q;
	logic [9:0]  code_q;
	logic        setup;
	logic        access;
	logic        wr;
	logic        rd_high;
	logic        hit;
	logic        finish;

	// ***************************************************
	// APB decode
	// ***************************************************
	assign setup   = PSEL && !PENABLE;
	assign access  = PSEL && PENABLE;
	assign wr      = access && PWRITE;
	assign rd_high = access && !PWRITE && (PADDR == ADDR_HIGH);
	assign PREADY  = 1'b1;
	assign PRDATA  = prdata_q;
	assign PSLVERR = access && pslverr_q;

	always_comb begin
		if (PADDR == ADDR_CSR) begin
			hit = 1'b1;
		end else if (PADDR == ADDR_HIGH) begin
			hit = 1'b1;
		end else if (PADDR == ADDR_LOW) begin
			hit = 1'b1;
		end else begin
			hit = 1'b0;
		end
	end

	// Read data is captured in the setup cycle so that it comes from a
	// flip-flop; the done flag may still rise before the access edge, and
	// that later value is then seen by the next poll, never lost.
	// A result that lands on the setup edge itself is missing from the
	// captured data, so that read must leave the done flag set.
	always_ff @(posedge MCLK) begin
		if (!RST_B) begin
			prdata_q     <= 32'h0000_0000;
			pslverr_q    <= 1'b0;
			high_stale_q <= 1'b0;
		end else if (setup) begin
			high_stale_q <= finish;
			pslverr_q <= !hit;
			prdata_q  <= 32'h0000_0000;
			if (PADDR == ADDR_CSR) begin
				prdata_q[CSR_DONE]  <= done_q;
				prdata_q[CSR_FAST]  <= fast_q;
				prdata_q[CSR_POWER] <= power_q;
				prdata_q[2:0]       <= chan_q;
			end else if (PADDR == ADDR_HIGH) begin
				prdata_q[7:0] <= result_q[9:2];
			end else if (PADDR == ADDR_LOW) begin
				prdata_q[LOW_CAL]   <= cal_q;
				prdata_q[LOW_QUART] <= quarter_q;
				prdata_q[LOW_GAIN]  <= gain_q;
				prdata_q[1:0]       <= result_q[1:0];
			end
		end
	end

	// ***************************************************
	// Control registers
	// ***************************************************
	// Reserved control bits 4:3 are not stored and read back as zero.
	always_ff @(posedge MCLK) begin
		if (!RST_B) begin
			power_q <= 1'b0;
			fast_q  <= 1'b0;
			chan_q  <= CHAN_RESET;
		end else if (wr && PADDR == ADDR_CSR) begin
			power_q <= PWDATA[CSR_POWER];
			fast_q  <= PWDATA[CSR_FAST];
			chan_q  <= PWDATA[2:0];
		end
	end

	always_ff @(posedge MCLK) begin
		if (!RST_B) begin
			cal_q     <= 1'b0;
			quarter_q <= 1'b0;
			gain_q    <= 1'b0;
		end else if (wr && PADDR == ADDR_LOW) begin
			cal_q     <= PWDATA[LOW_CAL];
			quarter_q <= PWDATA[LOW_QUART];
			gain_q    <= PWDATA[LOW_GAIN];
		end
	end

	// ***************************************************
	// Done flag
	// ***************************************************
	// A completion in the same cycle as the clearing read wins, so a fresh
	// result is always announced. Writes to the flag are ignored.
	always_ff @(posedge MCLK) begin
		if (!RST_B) begin
			done_q <= 1'b0;
		end else if (finish) begin
			done_q <= 1'b1;
		end else if (rd_high && !high_stale_q) begin
			done_q <= 1'b0;
		end
	end

	// Both halves load together; an unread result is simply replaced.
	always_ff @(posedge MCLK) begin
		if (!RST_B) begin
			result_q <= 10'h000;
		end else if (finish) begin
			result_q <= code_q;
		end
	end

	// ***************************************************
	// Converter clock divider
	// ***************************************************
	always_ff @(posedge MCLK) begin
		if (!RST_B) begin
			div_q <= 2'h0;
		end else if (!run) begin
			div_q <= 2'h0;
		end else begin
			div_q <= div_q + 2'h1;
		end
	end

	assign tick = run && tick_due(fast_q, quarter_q, div_q);

	// ***************************************************
	// Low-power handling
	// ***************************************************
	// Halt powers the converter down; after wakeup the analog part needs
	// time to settle, so conversions are held back by a counter.
	always_ff @(posedge MCLK) begin
		if (!RST_B) begin
			halt_q <= 1'b0;
		end else begin
			halt_q <= HALT_MODE;
		end
	end

	always_ff @(posedge MCLK) begin
		if (!RST_B) begin
			stab_q <= 12'h000;
		end else if (halt_q && !HALT_MODE) begin
			stab_q <= STAB_COUNT;
		end else if (stab_q != 12'h000) begin
			stab_q <= stab_q - 12'h001;
		end
	end

	// Idle sleep has no input here at all: it cannot touch conversions.
	// The delayed halt copy also blocks the wakeup cycle itself, before the
	// counter has been loaded.
	assign run = power_q && !HALT_MODE && !halt_q &&
	             (stab_q == 12'h000);

	// ***************************************************
	// Comparator synchroniser
	// ***************************************************
	always_ff @(posedge MCLK) begin
		if (!RST_B) begin
			comp_meta_q <= 1'b0;
			comp_q      <= 1'b0;
		end else begin
			comp_meta_q <= COMP_ABOVE;
			comp_q      <= comp_meta_q;
		end
	end

	// ***************************************************
	// Successive approximation sequencer
	// ***************************************************
	// Each bit waits several converter ticks so that the comparator answer
	// has crossed the synchroniser even at the undivided rate. Over-range
	// inputs keep every trial bit and under-range inputs drop them all.
	always_ff @(posedge MCLK) begin
		if (!RST_B) begin
			state_q <= ST_IDLE;
			step_q  <= 4'h0;
			bit_q   <= BIT_TOP;
			code_q  <= 10'h000;
		end else if (!run) begin
			state_q <= ST_IDLE;
			step_q  <= 4'h0;
			bit_q   <= BIT_TOP;
			code_q  <= 10'h000;
		end else begin
			case (state_q)
				ST_IDLE: begin
					state_q <= ST_SAMPLE;
					step_q  <= 4'h0;
				end
				ST_SAMPLE: begin
					if (tick) begin
						if (step_q == SAMPLE_TICKS - 4'h1) begin
							state_q <= ST_CONVERT;
							step_q  <= 4'h0;
							bit_q   <= BIT_TOP;
							code_q  <= CODE_MSB;
						end else begin
							step_q <= step_q + 4'h1;
						end
					end
				end
				ST_CONVERT: begin
					if (tick) begin
						if (step_q == BIT_TICKS - 4'h1) begin
							step_q <= 4'h0;
							if (bit_q == 4'h0) begin
								state_q <= ST_DONE;
								if (!comp_q) begin
									code_q <= code_q & ~bit_mask(bit_q);
								end
							end else begin
								bit_q <= bit_q - 4'h1;
								if (comp_q) begin
									code_q <= code_q | bit_mask(bit_q - 4'h1);
								end else begin
									code_q <= (code_q & ~bit_mask(bit_q)) |
									          bit_mask(bit_q - 4'h1);
								end
							end
						end else begin
							step_q <= step_q + 4'h1;
						end
					end
				end
				ST_DONE: begin
					state_q <= ST_SAMPLE;
					step_q  <= 4'h0;
				end
				default: begin
					state_q <= ST_IDLE;
				end
			endcase
		end
	end

	assign finish = run && (state_q == ST_DONE);

	// ***************************************************
	// Analog macro controls
	// ***************************************************
	// No interrupt output exists; software polls the done flag.
	assign CONV_POWER         = power_q && !HALT_MODE;
	assign AMP_POWER          = power_q && !HALT_MODE;
	assign GAIN_STAGE_SELECT  = gain_q;
	assign OFFSET_CALIBRATION = cal_q;
	assign CHANNEL_SELECT     = chan_q;
	assign CONVERTER_CLOCK    = tick;
	assign SAMPLE_HOLD        = (state_q == ST_SAMPLE);
	assign TRIAL_CODE         = code_q;

endmodule

// [bench/adc_ctrl_sva.sv]
// Port-level assertions for the converter control block.
`timescale 1ns/1ns

module adc_ctrl_sva
	import adc_ctrl_pkg::*;
(
	// Clock and reset
	input wire logic        MCLK,
	input wire logic        RST_B,
	// APB slave
	input wire logic        PSEL,
	input wire logic        PENABLE,
	input wire logic        PWRITE,
	input wire logic [11:0] PADDR,
	input wire logic [31:0] PWDATA,
	input wire logic [31:0] PRDATA,
	// Core and macro
	input wire logic        HALT_MODE,
	input wire logic        CONV_POWER,
	input wire logic        AMP_POWER,
	input wire logic        GAIN_STAGE_SELECT,
	input wire logic        OFFSET_CALIBRATION,
	input wire logic [2:0]  CHANNEL_SELECT,
	input wire logic        CONVERTER_CLOCK,
	input wire logic        SAMPLE_HOLD,
	input wire logic [9:0]  TRIAL_CODE
);
	default clocking @(posedge MCLK); endclocking
	default disable iff (!RST_B);

	sequence s_wr_csr;
		PSEL && PENABLE && PWRITE && PADDR == ADDR_CSR;
	endsequence
	sequence s_wr_low;
		PSEL && PENABLE && PWRITE && PADDR == ADDR_LOW;
	endsequence
	sequence s_sample_end;
		$fell(SAMPLE_HOLD) && CONV_POWER;
	endsequence

	a_power_pair: assert property (AMP_POWER == CONV_POWER)
		else $error("amplifier power differs");
	a_halt_off: assert property (HALT_MODE |-> !CONV_POWER)
		else $error("converter powered in halt");
	a_clock_idle: assert property (!CONV_POWER [*2] |-> !CONVERTER_CLOCK)
		else $error("converter clock runs while off");
	a_start_conv: assert property ($rose(CONV_POWER) |->
		##[1:300] (SAMPLE_HOLD || !CONV_POWER)) else $error("no sampling");
	a_chan_write: assert property (s_wr_csr |=>
		CHANNEL_SELECT == $past(PWDATA[2:0])) else $error("channel lost");
	a_cal_write: assert property (s_wr_low |=>
		OFFSET_CALIBRATION == $past(PWDATA[4])) else $error("cal lost");
	a_gain_write: assert property (s_wr_low |=>
		GAIN_STAGE_SELECT == $past(PWDATA[2])) else $error("gain lost");
	a_low_zero: assert property (PSEL && PENABLE && !PWRITE &&
		PADDR == ADDR_LOW |-> PRDATA[31:5] == 27'h0) else $error("bits set");
	a_msb_trial: assert property (s_sample_end |->
		##[0:1] TRIAL_CODE == CODE_MSB) else $error("first trial wrong");
	a_upper_zero: assert property (PSEL && PENABLE && !PWRITE |->
		PRDATA[31:8] == 24'h0) else $error("upper read bits set");
	a_wake_hold: assert property ($fell(HALT_MODE) |->
		!SAMPLE_HOLD [*8]) else $error("sampling right after wakeup");
endmodule

bind adc_control_interface adc_ctrl_sva chk (.MCLK, .RST_B, .PSEL, .PENABLE,
	.PWRITE, .PADDR, .PWDATA, .PRDATA, .HALT_MODE, .CONV_POWER, .AMP_POWER,
	.GAIN_STAGE_SELECT, .OFFSET_CALIBRATION, .CHANNEL_SELECT,
	.CONVERTER_CLOCK, .SAMPLE_HOLD, .TRIAL_CODE);

// [bench/adc_macro_model.sv]
// Behavioural model of the analog macro and its comparator.
`timescale 1ns/1ns

module adc_macro_model (
	// Macro controls
	input  wire logic       conv_power,
	input  wire logic       amp_power,
	input  wire logic       gain_sel,
	input  wire logic       cal_sel,
	input  wire logic [2:0] chan,
	input  wire logic [9:0] trial,
	// Comparator
	output logic            above
);
	// Levels in converter steps; a negative level lies below the low reference.
	int vin [7];
	int v;

	always_comb begin
		v = (chan < 3'h7) ? vin[chan] : 0;
		if (cal_sel)
			v = 0;
		if (gain_sel && amp_power)
			v = v * 8;
		above = conv_power && (v >= int'(trial));
	end
endmodule

// [bench/adc_control_interface_test.sv]
// Self-checking bench for the converter control block.
`timescale 1ns/1ns

module adc_control_interface_test
	import adc_ctrl_pkg::*;
;
	logic        MCLK = 0;
	logic        RST_B = 0, PSEL = 0, PENABLE = 0, PWRITE = 0, HALT_MODE = 0;
	logic [11:0] PADDR = '0;
	logic [31:0] PWDATA = '0;
	logic [31:0] PRDATA;
	logic [9:0]  TRIAL_CODE;
	logic [2:0]  CHANNEL_SELECT;
	logic        PREADY, PSLVERR, COMP_ABOVE, CONV_POWER, AMP_POWER;
	logic        GAIN_STAGE_SELECT, OFFSET_CALIBRATION, SAMPLE_HOLD;
	logic        CONVERTER_CLOCK, rerr;
	logic [7:0]  rdat;
	int          mismatches = 0;
	int          n_checks = 0;

	adc_control_interface uut (.MCLK, .RST_B, .PSEL, .PENABLE, .PWRITE,
		.PADDR, .PWDATA, .PRDATA, .PREADY, .PSLVERR, .HALT_MODE, .COMP_ABOVE,
		.CONV_POWER, .AMP_POWER, .GAIN_STAGE_SELECT, .OFFSET_CALIBRATION,
		.CHANNEL_SELECT, .CONVERTER_CLOCK, .SAMPLE_HOLD, .TRIAL_CODE);
	adc_macro_model macro (.conv_power(CONV_POWER), .amp_power(AMP_POWER),
		.gain_sel(GAIN_STAGE_SELECT), .cal_sel(OFFSET_CALIBRATION),
		.chan(CHANNEL_SELECT), .trial(TRIAL_CODE), .above(COMP_ABOVE));

	initial forever #20 MCLK = ~MCLK;

	task automatic conclude();
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	initial begin
		#3000000;
		mismatches++;
		conclude();
	end

	task automatic chk(input logic [9:0] got, input logic [9:0] exp);
		n_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("mismatch at %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d);
		@(posedge MCLK);
		PSEL <= 1;
		PENABLE <= 0;
		PWRITE <= wr;
		PADDR <= a;
		PWDATA <= {24'h0, d};
		@(posedge MCLK);
		PENABLE <= 1;
		do @(posedge MCLK); while (PREADY !== 1'b1);
		rdat = PRDATA[7:0];
		rerr = PSLVERR;
		PSEL <= 0;
		PENABLE <= 0;
	endtask

	function automatic logic [9:0] clip(input int v);
		return v < 0 ? 10'h000 : v > 1023 ? 10'h3FF : 10'(v);
	endfunction

	// Polls the done flag, up to 400 reads, then checks that it is set.
	task automatic wait_done();
		for (int i = 0; i < 400 && !rdat[7]; i++)
			apb(0, ADDR_CSR, 8'h00);
		chk({9'h0, rdat[7]}, 10'h001);
	endtask

	// The first result after a change may predate it, so it is thrown away.
	task automatic fresh(input logic [9:0] exp);
		logic [1:0] lo;
		repeat (2) begin
			rdat = 8'h00;
			wait_done();
			apb(0, ADDR_LOW, 8'h00);
			lo = rdat[1:0];
			apb(0, ADDR_HIGH, 8'h00);
		end
		chk({rdat, lo}, exp);
		apb(0, ADDR_CSR, 8'h00);
		chk({9'h0, rdat[7]}, 10'h000);
	endtask

	task automatic t_reset();
		apb(0, ADDR_CSR, 8'h00);
		chk({2'h0, rdat}, 10'h000);
		apb(0, ADDR_LOW, 8'h00);
		chk({2'h0, rdat}, 10'h000);
		apb(0, 12'hFFC, 8'h00);
		chk({1'b0, rerr, rdat}, 10'h100);
	endtask

	task automatic t_chan();
		for (int c = 0; c < 7; c++) begin
			apb(1, ADDR_CSR, {5'h14, 3'(c)});
			fresh(clip(macro.vin[c]));
		end
	endtask

	task automatic t_gain();
		apb(1, ADDR_CSR, 8'h20);
		// The slowest converter clock is chosen while the gain stage is on.
		apb(1, ADDR_LOW, 8'hEC);
		fresh(10'd720);
		apb(0, ADDR_LOW, 8'h00);
		chk({2'h0, rdat & 8'hFC}, 10'h00C);
		apb(1, ADDR_LOW, 8'h1C);
		fresh(10'h000);
		apb(1, ADDR_LOW, 8'h00);
	endtask

	task automatic t_clk(input logic [7:0] csr, low, input logic [9:0] exp);
		int n;
		apb(1, ADDR_CSR, csr);
		apb(1, ADDR_LOW, low);
		do @(posedge MCLK); while (SAMPLE_HOLD);
		do @(posedge MCLK); while (!(SAMPLE_HOLD && CONVERTER_CLOCK));
		n = 0;
		do begin
			@(posedge MCLK);
			n++;
		end while (CONVERTER_CLOCK !== 1'b1);
		chk(10'(n), exp);
	endtask

	task automatic t_off();
		int n;
		apb(1, ADDR_CSR, 8'h00);
		apb(0, ADDR_HIGH, 8'h00);
		repeat (300) @(posedge MCLK);
		apb(1, ADDR_CSR, 8'h80);
		apb(0, ADDR_CSR, 8'h00);
		chk({2'h0, rdat}, 10'h000);
		apb(1, ADDR_CSR, 8'h20);
		HALT_MODE <= 1;
		repeat (3) @(posedge MCLK);
		chk({9'h0, CONV_POWER}, 10'h000);
		HALT_MODE <= 0;
		n = 0;
		do begin
			@(posedge MCLK);
			n++;
		end while (!SAMPLE_HOLD && n < 1000);
		chk({9'h0, n > STAB_CYCLES}, 10'h001);
		fresh(10'd90);
		rdat = 8'h00;
		wait_done();
		apb(0, ADDR_HIGH, 8'h00);
		chk({2'h0, rdat}, clip(macro.vin[0]) >> 2);
		apb(0, ADDR_CSR, 8'h00);
		chk({9'h0, rdat[7]}, 10'h000);
	endtask

	initial begin
		macro.vin = '{90, 1023, 2000, -4, 512, 1, 700};
		repeat (8) @(posedge MCLK);
		RST_B <= 1;
		t_reset();
		t_chan();
		t_gain();
		t_clk(8'h20, 8'h00, 10'd2);
		t_clk(8'h60, 8'h00, 10'd1);
		t_clk(8'h60, 8'h08, 10'd4);
		t_off();
		conclude();
	end
endmodule
